// ### logic/dci_pkg.sv
// Package: constants for the daisy-chain interrupt logic.
// Assumes an 8-bit processor bus and six internal interrupt sources.
package dci_pkg;
    localparam int          DCI_NUM_SRC   = 6;
    localparam int          DCI_DATA_W    = 8;
    localparam logic [7:0]  DCI_OP_PREFIX = 8'hED;
    localparam logic [7:0]  DCI_OP_RETURN = 8'h4D;
    localparam logic [2:0]  DCI_VEC_NONE  = 3'h3;
    localparam int          DCI_VEC_LO    = 1;
    localparam int          DCI_VEC_HI    = 3;
    localparam logic [7:0]  DCI_VEC_RESET = 8'h00;
    typedef enum logic [1:0] {
        DCI_DEC_IDLE,
        DCI_DEC_PREFIX
    } dci_dec_t;
endpackage

// ### logic/dci_prio.sv
// Fixed-priority chain over the six internal sources, index 0 highest.
// Assumes channel A sources occupy the low indices.
`timescale 1ns/1ps
`default_nettype none
module dci_prio
    import dci_pkg::*;
(
    // Requests
    input  wire logic [DCI_NUM_SRC-1:0] i_req,
    // One-hot grant and any flag
    output logic      [DCI_NUM_SRC-1:0] o_grant,
    output logic                        o_any
);
    logic [DCI_NUM_SRC:0] blocked;

    assign blocked[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < DCI_NUM_SRC; g++) begin : g_chain
            assign o_grant[g]    = i_req[g] & ~blocked[g];
            assign blocked[g+1]  = blocked[g] | i_req[g];
        end
    endgenerate
    assign o_any = blocked[DCI_NUM_SRC];
endmodule
`default_nettype wire

// ### logic/dci_core.sv
// Daisy-chain interrupt request, acknowledge and return logic.
// Assumes bus strobes synchronous to i_clock; processor keeps its side.
// Function
// - With nothing pending or in service, chain enable out follows chain enable in.
// - With anything in service, or anything pending while no return prefix was seen, chain enable out is driven low.
// - Pending status is frozen while the opcode fetch strobe is low, except on the first cycle of an acknowledge.
// - On acknowledge with chain enable in high, the vector is driven and the in-service latch set.
// - The two-byte return opcode seen on fetches clears the in-service latch being serviced.
// - After the first return byte, pending but unacknowledged sources no longer pull chain enable out low.
// - If the next fetched byte is the second return byte, the served source with enable in high clears.
// - Six sources are arbitrated in fixed priority, channel A above channel B.
// - A higher source may request and be acknowledged while a lower one is in service.
// - A return command written by software clears the in-service latch as the opcode does.
// - With status vectors on and nothing pending, vector bits three to one read zero, one, one.
`timescale 1ns/1ps
`default_nettype none
module dci_core
    import dci_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   i_clock,
    input  wire logic                   i_reset,
    input  wire logic                   i_enable,
    // Processor bus
    input  wire logic                   i_opcode_fetch_strobe_n,
    input  wire logic                   i_io_request_strobe_n,
    input  wire logic [DCI_DATA_W-1:0]  i_data,
    // Sources and control
    input  wire logic [DCI_NUM_SRC-1:0] i_source_event,
    input  wire logic [DCI_DATA_W-1:0]  i_base_vector,
    input  wire logic                   i_status_vector_en,
    input  wire logic                   i_return_cmd,
    // Daisy chain
    input  wire logic                   i_chain_enable_in,
    output logic                        o_chain_enable_out,
    output logic                        o_int_request_n,
    // Vector drive
    output logic [DCI_DATA_W-1:0]       o_data,
    output logic                        o_data_oe,
    output logic [DCI_DATA_W-1:0]       o_vector_readback
);
    logic [DCI_NUM_SRC-1:0] pend_q, pend_d, serv_q, serv_d;
    logic [DCI_NUM_SRC-1:0] pgrant, sgrant, upper;
    logic                   pany, sany;
    dci_dec_t               dec_q, dec_d;
    logic                   ack_q, ack_d;
    logic                   ieo_q, ieo_d, irq_n_q, irq_n_d;
    logic [DCI_DATA_W-1:0]  data_q, data_d, rb_q, rb_d;
    logic                   oe_q, oe_d;
    logic                   fetch, ack, ack_rise, ret_done;
    logic [DCI_NUM_SRC-1:0] pend_vis, serv_clr;
    logic [DCI_NUM_SRC-1:0] held_q, held_d, vgrant;
    logic                   vany;
    logic [2:0]             pidx, vidx;

    dci_prio u_pend (
        .i_req   (pend_q),
        .o_grant (pgrant),
        .o_any   (pany)
    );
    dci_prio u_serv (
        .i_req   (serv_q),
        .o_grant (sgrant),
        .o_any   (sany)
    );
    dci_prio u_vis (
        .i_req   (pend_vis),
        .o_grant (vgrant),
        .o_any   (vany)
    );

    // Index of the highest pending and highest visible source
    always_comb begin
        pidx = '0;
        vidx = '0;
        for (int n = 0; n < DCI_NUM_SRC; n++) begin
            if (pgrant[n]) begin
                pidx = 3'(n);
            end
            if (vgrant[n]) begin
                vidx = 3'(n);
            end
        end
    end

    assign fetch    = ~i_opcode_fetch_strobe_n & i_io_request_strobe_n;
    assign ack      = ~i_opcode_fetch_strobe_n & ~i_io_request_strobe_n;
    assign ack_rise = ack & ~ack_q;

    // Pending only counts if no equal or higher source is in service
    always_comb begin
        upper = '0;
        for (int k = 1; k < DCI_NUM_SRC; k++) begin
            upper[k] = upper[k-1] | serv_q[k-1];
        end
        pend_vis = pend_q & ~upper & ~serv_q;
    end

    always_comb begin
        dec_d    = dec_q;
        ret_done = 1'b0;
        if (fetch) begin
            if (dec_q == DCI_DEC_PREFIX && i_data == DCI_OP_RETURN && i_chain_enable_in) begin
                ret_done = 1'b1;
            end
            dec_d = (i_data == DCI_OP_PREFIX) ? DCI_DEC_PREFIX : DCI_DEC_IDLE;
        end
        serv_clr = (ret_done | i_return_cmd) ? sgrant : '0;
    end

    always_comb begin
        pend_d  = pend_q | i_source_event | held_q;
        held_d  = '0;
        serv_d  = serv_q & ~serv_clr;
        ack_d   = ack;
        data_d  = data_q;
        oe_d    = 1'b0;
        if (ack_rise && i_chain_enable_in && vany) begin
            pend_d = (pend_q & ~vgrant) | i_source_event | held_q;
            serv_d = serv_d | vgrant;
            data_d = i_base_vector;
            if (i_status_vector_en) begin
                data_d[DCI_VEC_HI:DCI_VEC_LO] = vidx;
            end
        end
        if (ack && (ack_rise ? (i_chain_enable_in && vany) : oe_q)) begin
            oe_d = 1'b1;
        end
        // Events during the freeze wait in the holding mask
        if (!i_opcode_fetch_strobe_n && !ack_rise) begin
            pend_d = pend_q;
            held_d = held_q | i_source_event;
        end
        ieo_d = i_chain_enable_in;
        if (sany || (pany && dec_q != DCI_DEC_PREFIX)) begin
            ieo_d = 1'b0;
        end
        irq_n_d = ~(i_chain_enable_in && vany && !ack);
        rb_d    = i_base_vector;
        if (i_status_vector_en) begin
            rb_d[DCI_VEC_HI:DCI_VEC_LO] = pany ? pidx : DCI_VEC_NONE;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            pend_q  <= '0;
            held_q  <= '0;
            serv_q  <= '0;
            dec_q   <= DCI_DEC_IDLE;
            ack_q   <= 1'b0;
            ieo_q   <= 1'b0;
            irq_n_q <= 1'b1;
            data_q  <= DCI_VEC_RESET;
            oe_q    <= 1'b0;
            rb_q    <= DCI_VEC_RESET;
        end else if (i_enable) begin
            pend_q  <= pend_d;
            held_q  <= held_d;
            serv_q  <= serv_d;
            dec_q   <= dec_d;
            ack_q   <= ack_d;
            ieo_q   <= ieo_d;
            irq_n_q <= irq_n_d;
            data_q  <= data_d;
            oe_q    <= oe_d;
            rb_q    <= rb_d;
        end
    end

    assign o_chain_enable_out = ieo_q;
    assign o_int_request_n    = irq_n_q;
    assign o_data             = data_q;
    assign o_data_oe          = oe_q;
    assign o_vector_readback  = rb_q;

    AST_IDLE_FOLLOW: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && !sany && !pany |=> o_chain_enable_out == $past(i_chain_enable_in))
        else $error("chain out did not follow chain in");
    AST_SERV_BLOCK: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && sany |=> !o_chain_enable_out)
        else $error("chain out high while in service");
    AST_FREEZE: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && !i_opcode_fetch_strobe_n && !ack_rise |=> pend_q == $past(pend_q))
        else $error("pending changed during fetch");
    AST_ACK_SET: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && ack_rise && i_chain_enable_in && |pend_vis |=> o_data_oe && |(serv_q & ~$past(serv_q)))
        else $error("acknowledge did not set in-service");
    AST_RET_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && ret_done && sany |=> (serv_q & $past(sgrant)) == '0)
        else $error("return did not clear in-service");
    AST_CMD_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && i_return_cmd && sany |=> (serv_q & $past(sgrant)) == '0)
        else $error("return command did not clear");
    AST_PREFIX_OPEN: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && dec_q == DCI_DEC_PREFIX && !sany |=> o_chain_enable_out == $past(i_chain_enable_in))
        else $error("prefix did not release chain out");
    AST_REQ_GATE: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && !i_chain_enable_in |=> o_int_request_n)
        else $error("request without chain enable");
    AST_NONE_VEC: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && i_status_vector_en && !pany |=> o_vector_readback[DCI_VEC_HI:DCI_VEC_LO] == DCI_VEC_NONE)
        else $error("no-interrupt vector wrong");
    AST_REQ_RELEASE: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && ack |=> o_int_request_n)
        else $error("request held during acknowledge");
    AST_VEC_INDEX: assert property (@(posedge i_clock) disable iff (i_reset)
        i_enable && ack_rise && i_chain_enable_in && vany && i_status_vector_en
        |=> (serv_q & ~$past(serv_q)) == (DCI_NUM_SRC'(1) << o_data[DCI_VEC_HI:DCI_VEC_LO]))
        else $error("vector index does not match new in-service source");
    COV_ACK: cover property (@(posedge i_clock) disable iff (i_reset) ack_rise && o_data_oe == 1'b0 ##1 o_data_oe);
    COV_NEST: cover property (@(posedge i_clock) disable iff (i_reset) $countones(serv_q) == 2);
    COV_RET: cover property (@(posedge i_clock) disable iff (i_reset) ret_done && sany);
    COV_REFUSED: cover property (@(posedge i_clock) disable iff (i_reset) ack_rise && pany && !i_chain_enable_in);
endmodule
`default_nettype wire

// ### tb/dci_host.sv
// Host processor model: acknowledge cycles and two-byte opcode fetches.
// Assumes the core answers one cycle after acknowledge starts.
`timescale 1ns/1ps
`default_nettype none
module dci_host (
    // Clock and answer
    input  wire logic       i_clock,
    input  wire logic       i_data_oe,
    input  wire logic [7:0] i_vector,
    // Bus strobes and data
    output logic            o_opcode_fetch_strobe_n,
    output logic            o_io_request_strobe_n,
    output logic [7:0]      o_data
);
    initial begin
        o_opcode_fetch_strobe_n = 1'b1;
        o_io_request_strobe_n   = 1'b1;
        o_data                  = 8'hA5;
    end
    // Both strobes low together, answer taken after one edge
    task automatic ack(output logic oe, output logic [7:0] vec);
        @(posedge i_clock) #1;
        o_opcode_fetch_strobe_n = 1'b0;
        o_io_request_strobe_n   = 1'b0;
        @(posedge i_clock) #1;
        oe  = i_data_oe;
        vec = i_vector;
        @(posedge i_clock) #1;
        o_opcode_fetch_strobe_n = 1'b1;
        o_io_request_strobe_n   = 1'b1;
    endtask
    // Two fetch cycles back to back; released bus shows inverse
    task automatic fetch(input logic [7:0] b0, input logic [7:0] b1);
        @(posedge i_clock) #1;
        o_opcode_fetch_strobe_n = 1'b0;
        o_data                  = b0;
        @(posedge i_clock) #1;
        o_data                  = b1;
        @(posedge i_clock) #1;
        o_opcode_fetch_strobe_n = 1'b1;
        o_data                  = ~b1;
    endtask
endmodule
`default_nettype wire

// ### tb/test_daisy_chain_interrupt_logic.sv
// Testbench: events and host cycles checked against a bitmask model.
// Assumes dci_host as the processor and dci_core as the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_daisy_chain_interrupt_logic;
    import dci_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, cin = 1'b1, sv_en = 1'b0, rcmd = 1'b0, en = 1'b1;
    logic [5:0]  ev = 6'h00;
    logic [7:0]  base = 8'h00, hdata, odata, rb, vec;
    logic        fetch_n, ioreq_n, cout, req_n, oe, got_oe;
    int          checked = 0, miscompares = 0, pend = 0, insvc = 0, idx;
    int unsigned seed = 3566;
    always #2.5 clk = ~clk;
    dci_core i_dci_core (.i_clock(clk), .i_reset(rst), .i_enable(en),
        .i_opcode_fetch_strobe_n(fetch_n), .i_io_request_strobe_n(ioreq_n), .i_data(hdata),
        .i_source_event(ev), .i_base_vector(base), .i_status_vector_en(sv_en), .i_return_cmd(rcmd),
        .i_chain_enable_in(cin), .o_chain_enable_out(cout), .o_int_request_n(req_n),
        .o_data(odata), .o_data_oe(oe), .o_vector_readback(rb));
    dci_host i_dci_host (.i_clock(clk), .i_data_oe(oe), .i_vector(odata),
        .o_opcode_fetch_strobe_n(fetch_n), .o_io_request_strobe_n(ioreq_n), .o_data(hdata));
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int top(int m);
        for (int i = 0; i < DCI_NUM_SRC; i++) if (m[i]) return i;
        return DCI_NUM_SRC;
    endfunction
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
        `CHK("request_n", !(cin && top(pend) < top(insvc)), req_n)
        `CHK("chain_out", cin && pend == 0 && insvc == 0, cout)
        `CHK("readback", sv_en ? {base[7:4], pend == 0 ? DCI_VEC_NONE : 3'(top(pend)), base[0]} : base, rb)
    endtask
    task automatic fire(input logic [5:0] m);
        @(posedge clk) #1;
        ev = m;
        @(posedge clk) #1;
        ev = 6'h00;
        pend |= m;
        settle();
    endtask
    task automatic acknowledge();
        i_dci_host.ack(got_oe, vec);
        idx = top(pend);
        if (cin && idx < top(insvc)) begin
            pend[idx] = 1'b0;
            insvc[idx] = 1'b1;
            `CHK("vector_oe", 1'b1, got_oe)
            `CHK("vector", sv_en ? {base[7:4], idx[2:0], base[0]} : base, vec)
        end else `CHK("vector_oe", 1'b0, got_oe)
        settle();
    endtask
    task automatic ret(input bit by_cmd);
        if (by_cmd) begin
            @(posedge clk) #1;
            rcmd = 1'b1;
            @(posedge clk) #1;
            rcmd = 1'b0;
        end else i_dci_host.fetch(DCI_OP_PREFIX, DCI_OP_RETURN);
        if (by_cmd || cin) insvc[top(insvc)] = 1'b0;
        settle();
    endtask
    task automatic print_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        #1;
        `CHK("reset_oe", 1'b0, oe)
        `CHK("reset_request_n", 1'b1, req_n)
        rst = 1'b0;
        for (int it = 0; it < 8; it++) begin
            base = 8'(xs());
            sv_en = (xs() % 2 == 1);
            fire(6'(xs() % 63 + 1));
            while (pend != 0) begin
                acknowledge();
                if (xs() % 2 == 1) i_dci_host.fetch(DCI_OP_PREFIX, 8'h00);
                ret(xs() % 2 == 1);
            end
        end
        fire(6'h20);
        acknowledge();
        fire(6'h01);
        acknowledge();
        ret(1'b1);
        ret(1'b0);
        fire(6'h08);
        acknowledge();
        @(posedge clk) #1;
        rst = 1'b1;
        @(posedge clk) #1;
        `CHK("reset_chain_out", 1'b0, cout)
        `CHK("reset_request_n", 1'b1, req_n)
        rst = 1'b0;
        pend = 0;
        insvc = 0;
        settle();
        // Enable low: the event pulse must be lost
        en = 1'b0;
        ev = 6'h10;
        @(posedge clk) #1;
        ev = 6'h00;
        en = 1'b1;
        settle();
        cin = 1'b0;
        fire(6'h04);
        acknowledge();
        cin = 1'b1;
        settle();
        acknowledge();
        ret(1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
